/* design/ccrb_top.sv */
`timescale 1ns/1ps
`include "ccrb_map.svh"
// Summary of operation
// - Pre-charge and term currents are 128mA plus 128mA per code, reset 0001.
// - The 6-bit voltage limit is 3.504V plus 16mV per code, reset 4.208V.
// - The fast charge entry bit picks 2.8V or 3.0V and resets to 1.
// - The recharge offset bit picks 100mV or 300mV below regulation, reset 0.
// - Bit 7 of the termination/timer register enables termination, reset 1.
// - The keepalive period code picks off, 40s, 80s or 160s and resets to 01.
// - Safety timer enable resets to 1 and its 5/8/12/20 h code resets to 01.
// - The boost voltage is a 4-bit code of 64mV steps over 4.55V, reset 1001.
// - Boost hot select picks 33%, 36% or 30%, 11 turns off the disable but still flags a fault at 33%, reset 00.
// - Thermal regulation code picks 60, 80, 100 or 120 C, reset 11.
// - The four registers reset to 0x11, 0xB2, 0x9A and 0x93.
// - Keepalive expiry latches a readable watchdog fault flag.
// - Stretch halves the safety timer rate in input or thermal regulation.
module ccrb_top
	import ccrb_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h35,
	parameter int TICK_CYCLES = `CCRB_TICK_CYCLES,
	parameter int UNITS_PER_H = `CCRB_UNITS_PER_S * `CCRB_SEC_PER_H
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Serial port
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// Charger state
	input wire logic i_fast_charging,
	input wire logic i_timer_stretch_enable,
	input wire logic i_input_limiting,
	input wire logic i_thermal_regulating,
	input wire logic i_boost_mode,
	// Thermistor comparators, high when past the hot level
	input wire logic i_ts_hot_33,
	input wire logic i_ts_hot_36,
	input wire logic i_ts_hot_30,
	// Configuration and status
	output ccrb_cfg_t o_cfg,
	output logic o_boost_hot_disable,
	output logic o_watchdog_fault,
	output logic o_safety_timer_expired,
	output logic o_thermistor_hot
);
	localparam int DW = $clog2(TICK_CYCLES + 1);
	logic [7:0] cur_reg, cur_next, volt_reg, volt_next;
	logic [7:0] tt_reg, tt_next, bt_reg, bt_next, flt_reg, flt_next;
	logic [DW-1:0] div_reg, div_next;
	logic [9:0] wd_reg, wd_next, wd_limit;
	logic [23:0] sf_reg, sf_next, sf_limit;
	logic exp_reg, exp_next;
	logic wr_valid, rd_take, tick, wd_expire, sf_expire, hot_sel, hot_flt;
	logic [7:0] rd_addr, rd_data;
	ccrb_wr_t wr;
	ccrb_cfg_t cfg;

	ccrb_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_sda(o_sda),
		.o_sda_oe_n(o_sda_oe_n),
		.o_wr_valid(wr_valid),
		.o_wr(wr),
		.o_rd_addr(rd_addr),
		.o_rd_take(rd_take),
		.i_rd_data(rd_data)
	);

	// Field view of the registers
	always_comb begin
		cfg.precharge_current = cur_reg[`CCRB_PRE_LSB +: 4];
		cfg.term_current = cur_reg[`CCRB_TERM_CUR_LSB +: 4];
		cfg.charge_voltage_limit = volt_reg[`CCRB_VLIM_LSB +: 6];
		cfg.fast_charge_entry_threshold = volt_reg[`CCRB_ENTRY_BIT];
		cfg.recharge_offset = volt_reg[`CCRB_RECHG_BIT];
		cfg.termination_enable = tt_reg[`CCRB_TERM_EN_BIT];
		cfg.host_keepalive_period = tt_reg[`CCRB_KEEP_LSB +: 2];
		cfg.safety_timer_enable = tt_reg[`CCRB_TMR_EN_BIT];
		cfg.fast_charge_time_limit = tt_reg[`CCRB_TLIM_LSB +: 2];
		cfg.boost_output_voltage = bt_reg[`CCRB_BOOST_V_LSB +: 4];
		cfg.boost_hot_select = bt_reg[`CCRB_BHOT_LSB +: 2];
		cfg.thermal_regulation_limit = bt_reg[`CCRB_THREG_LSB +: 2];
	end

	// Register writes; reserved bits are masked off
	always_comb begin
		cur_next = cur_reg;
		volt_next = volt_reg;
		tt_next = tt_reg;
		bt_next = bt_reg;
		if (wr_valid) begin
			case (wr.addr)
				`CCRB_OFS_CURRENT: cur_next = wr.data;
				`CCRB_OFS_VOLTAGE: volt_next = wr.data;
				`CCRB_OFS_TERM_TIMER: tt_next = wr.data & `CCRB_MASK_TERM_TIMER;
				`CCRB_OFS_BOOST_THERM: bt_next = wr.data;
				default: begin
				end
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		case (rd_addr)
			`CCRB_OFS_CURRENT: rd_data = cur_reg;
			`CCRB_OFS_VOLTAGE: rd_data = volt_reg;
			`CCRB_OFS_TERM_TIMER: rd_data = tt_reg;
			`CCRB_OFS_BOOST_THERM: rd_data = bt_reg;
			`CCRB_OFS_FAULT: rd_data = flt_reg;
			default: rd_data = 8'h00;
		endcase
	end

	// Time base and keepalive limit in ticks
	always_comb begin
		tick = (div_reg == DW'(TICK_CYCLES - 1));
		div_next = tick ? '0 : div_reg + DW'(1);
		case (cfg.host_keepalive_period)
			2'h1: wd_limit = 10'(`CCRB_KEEP_1_S * `CCRB_TICKS_PER_S);
			2'h2: wd_limit = 10'(`CCRB_KEEP_2_S * `CCRB_TICKS_PER_S);
			2'h3: wd_limit = 10'(`CCRB_KEEP_3_S * `CCRB_TICKS_PER_S);
			default: wd_limit = 10'h000;
		endcase
		case (cfg.fast_charge_time_limit)
			2'h0: sf_limit = 24'(`CCRB_TLIM_0_H * UNITS_PER_H);
			2'h1: sf_limit = 24'(`CCRB_TLIM_1_H * UNITS_PER_H);
			2'h2: sf_limit = 24'(`CCRB_TLIM_2_H * UNITS_PER_H);
			default: sf_limit = 24'(`CCRB_TLIM_3_H * UNITS_PER_H);
		endcase
	end

	// Keepalive restarts on any register write
	always_comb begin
		wd_expire = 1'b0;
		wd_next = wd_reg;
		if (wr_valid || wd_limit == 10'h000) begin
			wd_next = 10'h000;
		end else if (tick) begin
			wd_expire = (wd_reg == wd_limit - 10'h001);
			wd_next = wd_expire ? 10'h000 : wd_reg + 10'h001;
		end
	end

	// Safety timer, half rate when stretched
	always_comb begin
		sf_next = sf_reg;
		sf_expire = 1'b0;
		exp_next = exp_reg;
		if (!i_fast_charging || !cfg.safety_timer_enable) begin
			sf_next = 24'h000000;
			exp_next = 1'b0;
		end else if (tick && !exp_reg) begin
			if (i_timer_stretch_enable &&
					(i_input_limiting || i_thermal_regulating)) begin
				sf_next = sf_reg + 24'h000001;
			end else begin
				sf_next = sf_reg + 24'h000002;
			end
			sf_expire = (sf_next >= sf_limit);
			exp_next = sf_expire;
		end
	end

	// Boost hot threshold choice
	always_comb begin
		case (cfg.boost_hot_select)
			CCRB_HOT_33: hot_sel = i_ts_hot_33;
			CCRB_HOT_36: hot_sel = i_ts_hot_36;
			CCRB_HOT_30: hot_sel = i_ts_hot_30;
			default: hot_sel = 1'b0;
		endcase
		hot_flt = (cfg.boost_hot_select == CCRB_HOT_OFF) ?
			i_ts_hot_33 : hot_sel;
	end

	// Latched faults clear on read; a new event wins
	always_comb begin
		flt_next = flt_reg;
		if (rd_take && rd_addr == `CCRB_OFS_FAULT) begin
			flt_next = 8'h00;
		end
		if (wd_expire) begin
			flt_next[`CCRB_FLT_WD_BIT] = 1'b1;
		end
		if (sf_expire) begin
			flt_next[`CCRB_FLT_CHG_LSB +: 2] = `CCRB_FLT_SAFETY_CODE;
		end
		if (i_boost_mode && hot_flt) begin
			flt_next[`CCRB_FLT_HOT_BIT] = 1'b1;
		end
	end

	// Register all state
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cur_reg <= `CCRB_RST_CURRENT;
			volt_reg <= `CCRB_RST_VOLTAGE;
			tt_reg <= `CCRB_RST_TERM_TIMER;
			bt_reg <= `CCRB_RST_BOOST_THERM;
			flt_reg <= `CCRB_RST_FAULT;
			div_reg <= '0;
			wd_reg <= 10'h000;
			sf_reg <= 24'h000000;
			exp_reg <= 1'b0;
		end else begin
			cur_reg <= cur_next;
			volt_reg <= volt_next;
			tt_reg <= tt_next;
			bt_reg <= bt_next;
			flt_reg <= flt_next;
			div_reg <= div_next;
			wd_reg <= wd_next;
			sf_reg <= sf_next;
			exp_reg <= exp_next;
		end
	end

	assign o_cfg = cfg;
	assign o_boost_hot_disable = i_boost_mode & hot_sel;
	assign o_watchdog_fault = flt_reg[`CCRB_FLT_WD_BIT];
	assign o_safety_timer_expired = exp_reg;
	assign o_thermistor_hot = flt_reg[`CCRB_FLT_HOT_BIT];

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence s_rst_done;
		$past(i_rst) && !i_rst;
	endsequence
	sequence s_write(logic [7:0] ofs);
		wr_valid && wr.addr == ofs;
	endsequence

	cur_reset_a: assert property (s_rst_done |->
		cfg.precharge_current == 4'h1 && cfg.term_current == 4'h1)
		else $error("current fields wrong after reset");
	vlim_reset_a: assert property (s_rst_done |->
		cfg.charge_voltage_limit == 6'h2C) else $error("voltage reset wrong");
	entry_write_a: assert property (s_write(`CCRB_OFS_VOLTAGE) |=>
		cfg.fast_charge_entry_threshold == $past(wr.data[1]))
		else $error("entry threshold not written");
	rechg_write_a: assert property (s_write(`CCRB_OFS_VOLTAGE) |=>
		cfg.recharge_offset == $past(wr.data[0]))
		else $error("recharge offset not written");
	term_write_a: assert property (s_write(`CCRB_OFS_TERM_TIMER) |=>
		cfg.termination_enable == $past(wr.data[7]))
		else $error("termination enable not written");
	keep_off_a: assert property ((cfg.host_keepalive_period == 2'h0)
		|-> !wd_expire) else $error("disabled keepalive expired");
	tmr_off_a: assert property (!cfg.safety_timer_enable |=>
		sf_reg == 24'h000000 && !exp_reg) else $error("timer ran disabled");
	boost_write_a: assert property (s_write(`CCRB_OFS_BOOST_THERM) |=>
		cfg.boost_output_voltage == $past(wr.data[7:4]))
		else $error("boost voltage not written");
	hot_pick_a: assert property ((i_boost_mode &&
		cfg.boost_hot_select == CCRB_HOT_36) |->
		o_boost_hot_disable == i_ts_hot_36) else $error("hot 36 wrong");
	hot_off_a: assert property ((i_boost_mode && i_ts_hot_33 &&
		cfg.boost_hot_select == CCRB_HOT_OFF) |->
		!o_boost_hot_disable ##1 o_thermistor_hot)
		else $error("unmonitored boost hot handling wrong");
	thermal_regulation_limit_reset_a: assert property (s_rst_done |->
		cfg.thermal_regulation_limit == 2'h3) else $error("thermal_regulation_limit reset");
	regs_reset_a: assert property (s_rst_done |->
		{cur_reg, volt_reg, tt_reg, bt_reg} == 32'h11B29A93)
		else $error("register reset values wrong");
	wd_latch_a: assert property (wd_expire |=>
		o_watchdog_fault [*2]) else $error("watchdog fault not latched");
	half_rate_a: assert property ((tick && i_fast_charging && !exp_reg
		&& cfg.safety_timer_enable && i_timer_stretch_enable &&
		i_thermal_regulating) |=> sf_reg == $past(sf_reg) + 24'h000001)
		else $error("safety timer not at half rate");
	rsvd_zero_a: assert property (tt_reg[6] == 1'b0 &&
		tt_reg[0] == 1'b0) else $error("reserved bit set");
endmodule

/* design/ccrb_map.svh */
`ifndef CCRB_MAP_SVH
`define CCRB_MAP_SVH

// Register offsets
`define CCRB_OFS_CURRENT 8'h03
`define CCRB_OFS_VOLTAGE 8'h04
`define CCRB_OFS_TERM_TIMER 8'h05
`define CCRB_OFS_BOOST_THERM 8'h06
`define CCRB_OFS_FAULT 8'h09

// Reset values
`define CCRB_RST_CURRENT 8'h11
`define CCRB_RST_VOLTAGE 8'hB2
`define CCRB_RST_TERM_TIMER 8'h9A
`define CCRB_RST_BOOST_THERM 8'h93
`define CCRB_RST_FAULT 8'h00

// Writable bits of the termination/timer register
`define CCRB_MASK_TERM_TIMER 8'hBE

// Field positions
`define CCRB_PRE_LSB 4
`define CCRB_TERM_CUR_LSB 0
`define CCRB_VLIM_LSB 2
`define CCRB_ENTRY_BIT 1
`define CCRB_RECHG_BIT 0
`define CCRB_TERM_EN_BIT 7
`define CCRB_KEEP_LSB 4
`define CCRB_TMR_EN_BIT 3
`define CCRB_TLIM_LSB 1
`define CCRB_BOOST_V_LSB 4
`define CCRB_BHOT_LSB 2
`define CCRB_THREG_LSB 0
`define CCRB_FLT_WD_BIT 7
`define CCRB_FLT_CHG_LSB 4
`define CCRB_FLT_HOT_BIT 0
`define CCRB_FLT_SAFETY_CODE 2'h3

// Timing
`define CCRB_CLK_PERIOD_NS 25
`define CCRB_TICK_MS 250
`define CCRB_KEEP_1_S 40
`define CCRB_KEEP_2_S 80
`define CCRB_KEEP_3_S 160
`define CCRB_TLIM_0_H 5
`define CCRB_TLIM_1_H 8
`define CCRB_TLIM_2_H 12
`define CCRB_TLIM_3_H 20
`define CCRB_SEC_PER_H 3600
// Safety count advances 2 per tick normally, 1 when stretched
`define CCRB_UNITS_PER_S (2 * 1000 / `CCRB_TICK_MS)
`define CCRB_TICK_CYCLES (`CCRB_TICK_MS * 1000000 / `CCRB_CLK_PERIOD_NS)
`define CCRB_TICKS_PER_S (1000 / `CCRB_TICK_MS)

`endif

/* design/ccrb_pkg.sv */
package ccrb_pkg;

	typedef struct packed {
		logic [3:0] precharge_current;
		logic [3:0] term_current;
		logic [5:0] charge_voltage_limit;
		logic fast_charge_entry_threshold;
		logic recharge_offset;
		logic termination_enable;
		logic [1:0] host_keepalive_period;
		logic safety_timer_enable;
		logic [1:0] fast_charge_time_limit;
		logic [3:0] boost_output_voltage;
		logic [1:0] boost_hot_select;
		logic [1:0] thermal_regulation_limit;
	} ccrb_cfg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} ccrb_wr_t;

	typedef enum logic [2:0] {
		CCRB_IDLE = 3'b000,
		CCRB_ADDR = 3'b001,
		CCRB_ACK_A = 3'b010,
		CCRB_WR = 3'b011,
		CCRB_ACK_W = 3'b100,
		CCRB_RD = 3'b101,
		CCRB_ACK_R = 3'b110
	} ccrb_i2c_st_t;

	typedef enum logic [1:0] {
		CCRB_HOT_33 = 2'b00,
		CCRB_HOT_36 = 2'b01,
		CCRB_HOT_30 = 2'b10,
		CCRB_HOT_OFF = 2'b11
	} ccrb_hot_sel_t;

endpackage

/* design/ccrb_i2c_slave.sv */
`timescale 1ns/1ps
module ccrb_i2c_slave
	import ccrb_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h35
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Serial port
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// Register side
	output logic o_wr_valid,
	output ccrb_wr_t o_wr,
	output logic [7:0] o_rd_addr,
	output logic o_rd_take,
	input wire logic [7:0] i_rd_data
);
	ccrb_i2c_st_t state_reg, state_next;
	logic scl_reg, sda_reg;
	logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next;
	logic [2:0] cnt_reg, cnt_next;
	logic full_reg, full_next, rw_reg, rw_next, ack_reg, ack_next;
	logic have_ptr_reg, have_ptr_next, oe_n_reg, oe_n_next;
	logic wr_valid_reg, wr_valid_next;
	ccrb_wr_t wr_reg, wr_next;
	logic rise, fall, start, stop, load;

	// Line events from the previous sample
	assign rise = i_scl & ~scl_reg;
	assign fall = ~i_scl & scl_reg;
	assign start = i_scl & scl_reg & sda_reg & ~i_sda;
	assign stop = i_scl & scl_reg & ~sda_reg & i_sda;

	// Bit sequencing and byte handling
	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		ptr_next = ptr_reg;
		cnt_next = cnt_reg;
		full_next = full_reg;
		rw_next = rw_reg;
		ack_next = ack_reg;
		have_ptr_next = have_ptr_reg;
		oe_n_next = oe_n_reg;
		wr_valid_next = 1'b0;
		wr_next = wr_reg;
		load = 1'b0;
		if (start) begin
			state_next = CCRB_ADDR;
			cnt_next = 3'h0;
			full_next = 1'b0;
			have_ptr_next = 1'b0;
			oe_n_next = 1'b1;
		end else if (stop) begin
			state_next = CCRB_IDLE;
			oe_n_next = 1'b1;
		end else if (rise) begin
			if (state_reg == CCRB_ADDR || state_reg == CCRB_WR) begin
				shift_next = {shift_reg[6:0], i_sda};
			end
			if (state_reg == CCRB_ADDR || state_reg == CCRB_WR ||
					state_reg == CCRB_RD) begin
				cnt_next = cnt_reg + 3'h1;
				full_next = (cnt_reg == 3'h7);
			end
			if (state_reg == CCRB_ACK_R) begin
				ack_next = ~i_sda;
			end
		end else if (fall) begin
			case (state_reg)
				CCRB_ADDR: begin
					if (full_reg) begin
						full_next = 1'b0;
						if (shift_reg[7:1] == DEV_ADDR) begin
							rw_next = shift_reg[0];
							oe_n_next = 1'b0;
							state_next = CCRB_ACK_A;
						end else begin
							state_next = CCRB_IDLE;
						end
					end
				end
				CCRB_ACK_A: begin
					if (rw_reg) begin
						load = 1'b1;
					end else begin
						oe_n_next = 1'b1;
						state_next = CCRB_WR;
					end
				end
				CCRB_WR: begin
					if (full_reg) begin
						full_next = 1'b0;
						oe_n_next = 1'b0;
						state_next = CCRB_ACK_W;
						if (have_ptr_reg) begin
							wr_valid_next = 1'b1;
							wr_next = '{addr: ptr_reg, data: shift_reg};
							ptr_next = ptr_reg + 8'h01;
						end else begin
							ptr_next = shift_reg;
							have_ptr_next = 1'b1;
						end
					end
				end
				CCRB_ACK_W: begin
					oe_n_next = 1'b1;
					state_next = CCRB_WR;
				end
				CCRB_RD: begin
					if (full_reg) begin
						full_next = 1'b0;
						oe_n_next = 1'b1;
						state_next = CCRB_ACK_R;
					end else begin
						oe_n_next = shift_reg[6];
						shift_next = {shift_reg[6:0], 1'b0};
					end
				end
				CCRB_ACK_R: begin
					if (ack_reg) begin
						load = 1'b1;
					end else begin
						state_next = CCRB_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
		if (load) begin
			shift_next = i_rd_data;
			oe_n_next = i_rd_data[7];
			ptr_next = ptr_reg + 8'h01;
			state_next = CCRB_RD;
		end
	end

	// Register the sequencer
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_reg <= CCRB_IDLE;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			shift_reg <= 8'h00;
			ptr_reg <= 8'h00;
			cnt_reg <= 3'h0;
			full_reg <= 1'b0;
			rw_reg <= 1'b0;
			ack_reg <= 1'b0;
			have_ptr_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			wr_valid_reg <= 1'b0;
			wr_reg <= '0;
		end else begin
			state_reg <= state_next;
			scl_reg <= i_scl;
			sda_reg <= i_sda;
			shift_reg <= shift_next;
			ptr_reg <= ptr_next;
			cnt_reg <= cnt_next;
			full_reg <= full_next;
			rw_reg <= rw_next;
			ack_reg <= ack_next;
			have_ptr_reg <= have_ptr_next;
			oe_n_reg <= oe_n_next;
			wr_valid_reg <= wr_valid_next;
			wr_reg <= wr_next;
		end
	end

	// Open drain: the pin is only ever pulled low
	assign o_sda = 1'b0;
	assign o_sda_oe_n = oe_n_reg;
	assign o_wr_valid = wr_valid_reg;
	assign o_wr = wr_reg;
	assign o_rd_addr = ptr_reg;
	assign o_rd_take = load;
endmodule

/* sim/ccrb_i2c_host.sv */
`timescale 1ns/1ps
module ccrb_i2c_host #(
	parameter logic [6:0] DEV_ADDR = 7'h35
) (
	// Clock and bus wire
	input wire logic i_ref_clk,
	input wire logic i_sda,
	// Bus drive, high releases the line
	output logic o_scl,
	output logic o_sda,
	// Read results and missing acknowledges
	output logic o_rd_done,
	output logic [7:0] o_rd_data,
	output logic [7:0] o_nack_cnt
);
	// Idle bus: both lines released
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		o_rd_done = 1'b0;
		o_rd_data = 8'h00;
		o_nack_cnt = 8'h00;
	end

	// Wait whole clock cycles
	task automatic tk(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask

	// One bit: data moves mid low phase, sampled late in the high phase
	task automatic bit_x(input logic b, output logic r);
		tk(2);
		o_sda <= b;
		tk(2);
		o_scl <= 1'b1;
		tk(3);
		r = i_sda;
		tk(1);
		o_scl <= 1'b0;
	endtask

	// Byte MSB first plus the ninth bit; counts a missing device ack
	task automatic byte_x(input logic [7:0] d, input logic chk,
			output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(1'b1, a);
		if (chk && a !== 1'b0) begin
			o_nack_cnt <= o_nack_cnt + 8'h01;
		end
	endtask

	// Start or repeated start: SDA falls while SCL is high
	task automatic start_c();
		tk(2);
		o_sda <= 1'b1;
		tk(2);
		o_scl <= 1'b1;
		tk(4);
		o_sda <= 1'b0;
		tk(4);
		o_scl <= 1'b0;
	endtask

	// Stop: SDA rises while SCL is high
	task automatic stop_c();
		tk(2);
		o_sda <= 1'b0;
		tk(2);
		o_scl <= 1'b1;
		tk(4);
		o_sda <= 1'b1;
		tk(4);
	endtask

	// Single register write, then the keepalive restart spacing
	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		logic [7:0] q;
		start_c();
		byte_x({DEV_ADDR, 1'b0}, 1'b1, q);
		byte_x(adr, 1'b1, q);
		byte_x(d, 1'b1, q);
		stop_c();
		tk(800);
	endtask

	// Random read: pointer write, repeated start, one byte with NACK
	task automatic rd(input logic [7:0] adr);
		logic [7:0] q;
		logic a;
		start_c();
		byte_x({DEV_ADDR, 1'b0}, 1'b1, q);
		byte_x(adr, 1'b1, q);
		start_c();
		byte_x({DEV_ADDR, 1'b1}, 1'b1, q);
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, q[i]);
		end
		bit_x(1'b1, a); // Master NACK ends the read
		stop_c();
		o_rd_data <= q;
		o_rd_done <= 1'b1;
		tk(1);
		o_rd_done <= 1'b0;
	endtask
endmodule

/* sim/tb_ccrb_top.sv */
`timescale 1ns/1ps
module tb_ccrb_top;
	import ccrb_pkg::*;
	localparam int TICK = 40;
	// Clock, reset and charger stimulus
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic fast_chg = 1'b0;
	logic stretch = 1'b0;
	logic limiting = 1'b0;
	logic thermal = 1'b0;
	logic boost = 1'b0;
	logic [2:0] hot = 3'h0;
	// Serial bus and outputs
	logic scl, h_sda, sda_w, o_sda, o_sda_oe_n, rd_done;
	logic [7:0] rd_data, nack_cnt;
	ccrb_cfg_t cfg;
	logic hot_dis, wd_fault, st_exp, th_hot;
	// Bookkeeping
	logic [7:0] shadow [3:6];
	logic [39:0] exp_q [$];
	int n_mismatch = 0;
	int tests_run = 0;

	// Open-drain line with pull-up
	assign sda_w = h_sda & (o_sda_oe_n | o_sda);

	ccrb_top #(.DEV_ADDR(7'h35), .TICK_CYCLES(TICK), .UNITS_PER_H(8))
			ccrb_top_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
			.i_scl(scl), .i_sda(sda_w), .o_sda(o_sda),
			.o_sda_oe_n(o_sda_oe_n), .i_fast_charging(fast_chg),
			.i_timer_stretch_enable(stretch), .i_input_limiting(limiting),
			.i_thermal_regulating(thermal), .i_boost_mode(boost),
			.i_ts_hot_33(hot[0]), .i_ts_hot_36(hot[1]),
			.i_ts_hot_30(hot[2]), .o_cfg(cfg), .o_boost_hot_disable(hot_dis),
			.o_watchdog_fault(wd_fault), .o_safety_timer_expired(st_exp),
			.o_thermistor_hot(th_hot));

	ccrb_i2c_host #(.DEV_ADDR(7'h35)) ccrb_i2c_host_inst (
			.i_ref_clk(i_ref_clk), .i_sda(sda_w), .o_scl(scl), .o_sda(h_sda),
			.o_rd_done(rd_done), .o_rd_data(rd_data), .o_nack_cnt(nack_cnt));

	// 40 MHz clock
	initial begin
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	// Compare and count
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Note the expected byte, then read it over the bus
	task automatic rd_exp(input logic [7:0] adr, input logic [7:0] exp);
		exp_q.push_back({32'h0, exp});
		ccrb_i2c_host_inst.rd(adr);
	endtask

	// Write a register and track what it should hold
	task automatic wr_reg(input logic [7:0] adr, input logic [7:0] d);
		ccrb_i2c_host_inst.wr(adr, d);
		if (adr >= 8'h03 && adr <= 8'h06) begin
			shadow[adr] = (adr == 8'h05) ? (d & 8'hBE) : d;
		end
	endtask

	// Expected field view of the four registers
	function automatic logic [39:0] cfg_of();
		return 40'({shadow[3], shadow[4], shadow[5][7], shadow[5][5:1],
			shadow[6]});
	endfunction

	// Read-result watcher takes the oldest note
	always @(posedge i_ref_clk) begin
		if (rd_done === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
			end else begin
				check(40'(rd_data), exp_q.pop_front());
			end
		end
	end

	// Hang guard
	initial begin
		repeat (80000) @(posedge i_ref_clk);
		n_mismatch++;
		summarize();
	end

	// Main sequence
	initial begin
		int base;
		base = $urandom(32'h8e781bb2);
		shadow[3] = 8'h11;
		shadow[4] = 8'hB2;
		shadow[5] = 8'h9A;
		shadow[6] = 8'h93;
		repeat (16) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(negedge i_ref_clk);
		check(40'(cfg), cfg_of());
		for (int a = 3; a <= 6; a++) begin
			rd_exp(8'(a), shadow[a]);
		end
		// Unmapped and fault offsets ignore writes
		wr_reg(8'h0C, 8'hFF);
		wr_reg(8'h09, 8'hFF);
		rd_exp(8'h0C, 8'h00);
		rd_exp(8'h09, 8'h00);
		// Random values everywhere, reserved bits dropped
		for (int a = 3; a <= 6; a++) begin
			wr_reg(8'(a), 8'($urandom));
		end
		for (int a = 3; a <= 6; a++) begin
			rd_exp(8'(a), shadow[a]);
		end
		@(negedge i_ref_clk);
		check(40'(cfg), cfg_of());
		// Keepalive of 40 s, then 80 s, expires with no further writes
		for (int p = 1; p <= 2; p++) begin
			wr_reg(8'h05, {4'(8 + p), 4'hA});
			repeat (p * 160 * TICK - 1000) @(posedge i_ref_clk);
			@(negedge i_ref_clk);
			check(40'(wd_fault), 40'h0);
			repeat (400) @(posedge i_ref_clk);
			@(negedge i_ref_clk);
			check(40'(wd_fault), 40'h1);
			rd_exp(8'h09, 8'h80);
		end
		// Five hour limit at full and half rate, then twenty hours
		wr_reg(8'h05, 8'h88);
		for (int m = 0; m < 4; m++) begin
			if (m == 3) begin
				wr_reg(8'h05, 8'h8E);
			end
			base = (m == 0) ? 800 : (m == 3) ? 3200 : 1600;
			@(posedge i_ref_clk);
			stretch <= (m == 1 || m == 2);
			limiting <= (m != 2);
			thermal <= (m != 1);
			fast_chg <= 1'b1;
			repeat (base - 100) @(posedge i_ref_clk);
			@(negedge i_ref_clk);
			check(40'(st_exp), 40'h0);
			repeat (200) @(posedge i_ref_clk);
			@(negedge i_ref_clk);
			check(40'(st_exp), 40'h1);
			@(posedge i_ref_clk);
			fast_chg <= 1'b0;
			repeat (4) @(negedge i_ref_clk);
			check(40'(st_exp), 40'h0);
		end
		rd_exp(8'h09, 8'h30);
		// Every hot select against every comparator
		boost <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			wr_reg(8'h06, {shadow[6][7:4], 2'(s), shadow[6][1:0]});
			for (int k = 0; k < 3; k++) begin
				@(posedge i_ref_clk);
				hot <= 3'(1 << k);
				repeat (2) @(negedge i_ref_clk);
				check(40'(hot_dis), 40'(s == k));
			end
		end
		boost <= 1'b0;
		hot <= 3'h0;
		rd_exp(8'h09, 8'h01);
		// Select 11: no disable, fault only from the 33 percent level
		@(posedge i_ref_clk);
		boost <= 1'b1;
		hot <= 3'h6;
		repeat (3) @(negedge i_ref_clk);
		check(40'({hot_dis, th_hot}), 40'h0);
		@(posedge i_ref_clk);
		hot <= 3'h1;
		repeat (3) @(negedge i_ref_clk);
		check(40'({hot_dis, th_hot}), 40'h1);
		check(40'(nack_cnt), 40'h0);
		// Every noted read result must have come back
		check(40'(exp_q.size()), 40'h0);
		summarize();
	end
endmodule
